// ### i2mb_pkg.sv
// package: constants, states and carriers of the i2c master byte engine
package i2mb_pkg;
  // ==========================================================
  // clock and bus pacing
  localparam int CLK_MHZ = 125;
  localparam int BUS_KHZ = 100;
  localparam int PHASES_PER_BIT = 4;
  // longest tick period rounds down to whole cycles
  localparam int TICK_CYCLES = (CLK_MHZ * 1000) / (BUS_KHZ * PHASES_PER_BIT);
  localparam logic [15:0] TICK_RELOAD_RST = 16'(TICK_CYCLES - 1);
  // ==========================================================
  // transfer geometry
  localparam int BUF_DEPTH = 7;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] SUB_FIRST = 2'h0;
  localparam logic [1:0] SUB_RISE = 2'h1;
  localparam logic [1:0] SUB_SAMPLE = 2'h2;
  localparam logic [1:0] SUB_LAST = 2'h3;
  localparam logic [2:0] ONE_BYTE = 3'h1;
  localparam logic [2:0] IDX_ZERO = 3'h0;
  localparam logic [6:0] ADDR_RST = 7'h00;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  // ==========================================================
  // register map (byte addresses)
  localparam int AW = 6;
  localparam logic [5:0] OFS_CMD_STATUS = 6'h00;
  localparam logic [5:0] OFS_ADDR = 6'h04;
  localparam logic [5:0] OFS_COUNT = 6'h08;
  localparam logic [5:0] OFS_TICK = 6'h0c;
  localparam logic [5:0] OFS_WAIT = 6'h10;
  localparam logic [5:0] OFS_BUF0 = 6'h20;
  localparam logic [5:0] OFS_BUF_LAST = 6'h38;
  // status fields
  localparam int ST_BUSY = 0;
  localparam int ST_NO_ACK = 1;
  localparam int ST_RX_DONE = 2;
  // ==========================================================
  // commands written to the command register
  localparam logic [2:0] CMD_WRITE_ONE = 3'h1;
  localparam logic [2:0] CMD_WRITE_MANY = 3'h2;
  localparam logic [2:0] CMD_READ_ONE = 3'h3;
  localparam logic [2:0] CMD_READ_MANY = 3'h4;
  localparam logic [2:0] CMD_INIT = 3'h5;
  // ==========================================================
  // machine states, one-hot
  typedef enum logic [11:0] {
    ST_IDLE = 12'h001,
    ST_START_COND = 12'h002,
    ST_PREP_TX = 12'h004,
    ST_SHIFT_OUT = 12'h008,
    ST_SAMPLE_ACK = 12'h010,
    ST_MORE_TX = 12'h020,
    ST_STOP_COND = 12'h040,
    ST_PREP_ADDR_RX = 12'h080,
    ST_PREP_RX = 12'h100,
    ST_SHIFT_IN = 12'h200,
    ST_STORE_RX = 12'h400,
    ST_DRIVE_ACK = 12'h800
  } i2mb_state_e;
  // pull-low requests for both bus lines
  typedef struct packed {
    logic scl_low;
    logic sda_low;
  } i2mb_line_s;
endpackage : i2mb_pkg

// ### i2mb_sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module i2mb_sync3 (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // raw and filtered level
  input wire logic raw,
  output logic level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  // ==========================================================
  // synchroniser chain; s1 feeds only s2
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // level changes once the two later stages agree
  always_ff @(posedge clk) begin
    if (rst) level_q <= 1'b1;
    else if (s2_q == s3_q) level_q <= s3_q;
  end

  assign level = level_q;
endmodule : i2mb_sync3
`default_nettype wire

// ### i2mb_tick_timer.sv
// tick timer: reloadable down counter that paces the state machine
`timescale 1ns/1ns
`default_nettype none
module i2mb_tick_timer #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // reload value and tick pulse
  input wire logic [W-1:0] reload,
  output logic tick
);
  logic [W-1:0] cnt_q;
  logic tick_q;

  // ==========================================================
  // count down, pulse and reload at zero; a new reload applies next wrap
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (cnt_q == '0) begin
      cnt_q <= reload;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q - 1'b1;
      tick_q <= 1'b0;
    end
  end

  assign tick = tick_q;
endmodule : i2mb_tick_timer
`default_nettype wire

// ### i2mb_master.sv
// i2c master byte engine with avalon-mm register slave
// Overview of operation
// - bus runs near 100 kHz; tick timer reload value sets the rate.
// - write-one command is write-many with byte count forced to one.
// - wait-done returns only when idle; 0 on ack, 1 on no-ack.
// - read-one fetches one byte, returned as result and in buffer.
// - read-many fetches byte count bytes into the buffer in order.
// - no-ack flag set when slave failed to acknowledge last transaction.
// - receive-complete flag set once all requested bytes are read.
// - bit counter holds bits left; byte states preload a full byte.
// - transfer buffer holds seven bytes, indexed during transfers.
// - idle keeps both lines released and the bus quiet.
// - each command opens with sda falling while scl stays high; CMD_INIT sends no start and leaves both lines released.
// - before each outgoing byte reload bit counter and fetch the byte.
// - sample ack after each sent byte; on no-ack stop and flag it.
// - after an acked byte send the next one if any remain.
// - stop is sda rising while scl is high, then back to idle.
// - read first sends stored address through the normal write path; ST_PREP_ADDR_RX loads it with the read bit, not ST_PREP_TX.
// - receive shifts in eight bits after reloading the bit counter.
// - each received byte goes into the next buffer position.
// - after a received byte ack if more remain, else not-ack.
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module i2mb_master
  import i2mb_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // avalon-mm slave
  input wire logic [AW-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // i2c clock line, open drain
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE,
  // i2c data line, open drain
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE
);
  // ==========================================================
  // state
  i2mb_state_e machine_state_q;
  logic [1:0] machine_substate_q;
  i2mb_line_s line_direction_shadow_q;
  i2mb_line_s line_d;
  logic [3:0] bits_left_counter_q;
  logic [7:0] shift_byte_q;
  logic [2:0] write_index_q;
  logic [2:0] byte_count_q;
  logic [6:0] target_address_q;
  logic [15:0] tick_reload_q;
  logic [7:0] transfer_buffer_q [BUF_DEPTH];
  logic dir_read_q;
  logic first_q;
  logic ack_bit_q;
  logic no_ack_flag_q;
  logic rx_complete_flag_q;
  logic ack_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic low_level_q;
  logic tick;
  logic scl_in;
  logic sda_in;
  logic adv;
  logic busy;
  logic req;
  logic take;
  logic cmd_go;
  logic [2:0] cmd;
  logic more_rx;
  logic [31:0] rdata_d;

  // ==========================================================
  // pacing and pin inputs
  i2mb_tick_timer #(.W(16)) u_tick (
    .clk(CLK),
    .rst(RST),
    .reload(tick_reload_q),
    .tick(tick)
  );
  i2mb_sync3 u_scl_sync (.clk(CLK), .rst(RST), .raw(SCL_I), .level(scl_in));
  i2mb_sync3 u_sda_sync (.clk(CLK), .rst(RST), .raw(SDA_I), .level(sda_in));

  // hold a phase while a slave stretches the released clock low
  assign adv = tick && !(!line_direction_shadow_q.scl_low && !scl_in && busy);
  assign busy = (machine_state_q != ST_IDLE);
  assign more_rx = (write_index_q < byte_count_q);

  // ==========================================================
  // bus slave handshake: one wait cycle, wait register stalls until idle
  assign req = (AVS_READ || AVS_WRITE) && !ack_q;
  assign take = req && !(AVS_READ && AVS_ADDRESS == OFS_WAIT && busy);
  assign cmd = AVS_WRITEDATA[2:0];
  // all commands, init included, are refused while busy
  assign cmd_go = take && AVS_WRITE && AVS_ADDRESS == OFS_CMD_STATUS && !busy;

  // waitrequest keeps its own flop so the pin leaves straight from a register
  always_ff @(posedge CLK) begin
    if (RST) begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
    end else begin
      ack_q <= take;
      wait_q <= !take;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = '0;
    if (AVS_ADDRESS >= OFS_BUF0 && AVS_ADDRESS <= OFS_BUF_LAST) begin
      rdata_d[7:0] = transfer_buffer_q[3'(AVS_ADDRESS[4:2] - OFS_BUF0[4:2])];
    end else begin
      unique case (AVS_ADDRESS)
        OFS_CMD_STATUS: begin
          rdata_d[ST_BUSY] = busy;
          rdata_d[ST_NO_ACK] = no_ack_flag_q;
          rdata_d[ST_RX_DONE] = rx_complete_flag_q;
        end
        OFS_ADDR: rdata_d[6:0] = target_address_q;
        OFS_COUNT: rdata_d[2:0] = byte_count_q;
        OFS_TICK: rdata_d[15:0] = tick_reload_q;
        OFS_WAIT: begin
          rdata_d[0] = no_ack_flag_q;
          rdata_d[15:8] = transfer_buffer_q[0];
        end
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) rdata_q <= '0;
    else if (take && AVS_READ) rdata_q <= rdata_d;
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      target_address_q <= ADDR_RST;
      byte_count_q <= ONE_BYTE;
      tick_reload_q <= TICK_RELOAD_RST;
    end else if (take && AVS_WRITE) begin
      if (AVS_ADDRESS == OFS_ADDR) target_address_q <= AVS_WRITEDATA[6:0];
      if (AVS_ADDRESS == OFS_COUNT && !busy) byte_count_q <= AVS_WRITEDATA[2:0];
      if (AVS_ADDRESS == OFS_TICK) tick_reload_q <= AVS_WRITEDATA[15:0];
      if (cmd_go && (cmd == CMD_WRITE_ONE || cmd == CMD_READ_ONE)) begin
        byte_count_q <= ONE_BYTE;
      end
    end
  end

  // ==========================================================
  // seven-entry transfer buffer; received bytes win over a bus write
  always_ff @(posedge CLK) begin
    if (machine_state_q == ST_STORE_RX && adv) begin
      transfer_buffer_q[write_index_q] <= shift_byte_q;
    end else if (take && AVS_WRITE && AVS_ADDRESS >= OFS_BUF0
                 && AVS_ADDRESS <= OFS_BUF_LAST) begin
      transfer_buffer_q[3'(AVS_ADDRESS[4:2] - OFS_BUF0[4:2])] <= AVS_WRITEDATA[7:0];
    end
  end

  // ==========================================================
  // flags: cleared only when a command starts, set only while busy
  always_ff @(posedge CLK) begin
    if (RST) begin
      no_ack_flag_q <= 1'b0;
      rx_complete_flag_q <= 1'b0;
    end else if (cmd_go && cmd >= CMD_WRITE_ONE && cmd <= CMD_INIT) begin
      no_ack_flag_q <= 1'b0;
      rx_complete_flag_q <= 1'b0;
    end else if (adv && machine_state_q == ST_SAMPLE_ACK
                 && machine_substate_q == SUB_LAST && ack_bit_q) begin
      no_ack_flag_q <= 1'b1;
    end else if (adv && machine_state_q == ST_DRIVE_ACK
                 && machine_substate_q == SUB_LAST && !more_rx) begin
      rx_complete_flag_q <= 1'b1;
    end
  end

  // ==========================================================
  // main state machine, stepped by the tick
  always_ff @(posedge CLK) begin
    if (RST) begin
      machine_state_q <= ST_IDLE;
      machine_substate_q <= SUB_FIRST;
      bits_left_counter_q <= '0;
      shift_byte_q <= '0;
      write_index_q <= IDX_ZERO;
      dir_read_q <= DIR_WRITE;
      first_q <= 1'b0;
      ack_bit_q <= 1'b0;
    end else if (cmd_go && cmd == CMD_INIT) begin
      machine_state_q <= ST_IDLE;
      machine_substate_q <= SUB_FIRST;
    end else if (cmd_go && cmd >= CMD_WRITE_ONE && cmd <= CMD_READ_MANY) begin
      machine_state_q <= ST_START_COND;
      machine_substate_q <= SUB_FIRST;
      write_index_q <= IDX_ZERO;
      first_q <= 1'b1;
      dir_read_q <= (cmd == CMD_READ_ONE || cmd == CMD_READ_MANY) ? DIR_READ : DIR_WRITE;
    end else if (adv) begin
      machine_substate_q <= machine_substate_q + 2'h1;
      unique case (machine_state_q)
        ST_IDLE: machine_substate_q <= SUB_FIRST;
        ST_START_COND: begin
          if (machine_substate_q == SUB_LAST) begin
            machine_state_q <= dir_read_q ? ST_PREP_ADDR_RX : ST_PREP_TX;
          end
        end
        ST_PREP_TX: begin
          machine_substate_q <= SUB_FIRST;
          bits_left_counter_q <= BITS_PER_BYTE;
          if (first_q) begin
            shift_byte_q <= {target_address_q, DIR_WRITE};
          end else begin
            shift_byte_q <= transfer_buffer_q[write_index_q];
            write_index_q <= write_index_q + 3'h1;
          end
          first_q <= 1'b0;
          machine_state_q <= ST_SHIFT_OUT;
        end
        ST_PREP_ADDR_RX: begin
          machine_substate_q <= SUB_FIRST;
          bits_left_counter_q <= BITS_PER_BYTE;
          shift_byte_q <= {target_address_q, DIR_READ};
          first_q <= 1'b0;
          machine_state_q <= ST_SHIFT_OUT;
        end
        ST_SHIFT_OUT: begin
          if (machine_substate_q == SUB_LAST) begin
            shift_byte_q <= {shift_byte_q[6:0], 1'b0};
            bits_left_counter_q <= bits_left_counter_q - 4'h1;
            if (bits_left_counter_q == 4'h1) machine_state_q <= ST_SAMPLE_ACK;
          end
        end
        ST_SAMPLE_ACK: begin
          if (machine_substate_q == SUB_SAMPLE) ack_bit_q <= sda_in;
          if (machine_substate_q == SUB_LAST) begin
            if (ack_bit_q) machine_state_q <= ST_STOP_COND;
            else if (dir_read_q) machine_state_q <= ST_PREP_RX;
            else machine_state_q <= ST_MORE_TX;
          end
        end
        ST_MORE_TX: begin
          machine_substate_q <= SUB_FIRST;
          machine_state_q <= (write_index_q < byte_count_q) ? ST_PREP_TX : ST_STOP_COND;
        end
        ST_PREP_RX: begin
          machine_substate_q <= SUB_FIRST;
          bits_left_counter_q <= BITS_PER_BYTE;
          machine_state_q <= ST_SHIFT_IN;
        end
        ST_SHIFT_IN: begin
          if (machine_substate_q == SUB_SAMPLE) begin
            shift_byte_q <= {shift_byte_q[6:0], sda_in};
          end
          if (machine_substate_q == SUB_LAST) begin
            bits_left_counter_q <= bits_left_counter_q - 4'h1;
            if (bits_left_counter_q == 4'h1) machine_state_q <= ST_STORE_RX;
          end
        end
        ST_STORE_RX: begin
          machine_substate_q <= SUB_FIRST;
          write_index_q <= write_index_q + 3'h1;
          machine_state_q <= ST_DRIVE_ACK;
        end
        ST_DRIVE_ACK: begin
          if (machine_substate_q == SUB_LAST) begin
            machine_state_q <= more_rx ? ST_PREP_RX : ST_STOP_COND;
          end
        end
        ST_STOP_COND: begin
          if (machine_substate_q == SUB_LAST) machine_state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // line drive per state and phase; only pull-low requests exist
  always_comb begin
    line_d = line_direction_shadow_q;
    unique case (machine_state_q)
      ST_IDLE: line_d = '{scl_low: 1'b0, sda_low: 1'b0};
      ST_START_COND: begin
        line_d.scl_low = (machine_substate_q >= SUB_SAMPLE);
        line_d.sda_low = (machine_substate_q != SUB_FIRST);
      end
      ST_SHIFT_OUT: begin
        line_d.scl_low = (machine_substate_q == SUB_FIRST || machine_substate_q == SUB_LAST);
        line_d.sda_low = !shift_byte_q[7];
      end
      ST_SAMPLE_ACK, ST_SHIFT_IN: begin
        line_d.scl_low = (machine_substate_q == SUB_FIRST || machine_substate_q == SUB_LAST);
        line_d.sda_low = 1'b0;
      end
      ST_DRIVE_ACK: begin
        line_d.scl_low = (machine_substate_q == SUB_FIRST || machine_substate_q == SUB_LAST);
        line_d.sda_low = more_rx;
      end
      ST_STOP_COND: begin
        line_d.scl_low = (machine_substate_q == SUB_FIRST);
        line_d.sda_low = (machine_substate_q < SUB_SAMPLE);
      end
      ST_PREP_TX, ST_PREP_ADDR_RX, ST_MORE_TX, ST_PREP_RX, ST_STORE_RX: begin
        line_d.scl_low = 1'b1;
      end
      default: line_d = '{scl_low: 1'b0, sda_low: 1'b0};
    endcase
  end

  // shadow feeds the enables directly; output level is always low
  always_ff @(posedge CLK) begin
    if (RST) begin
      line_direction_shadow_q <= '{scl_low: 1'b0, sda_low: 1'b0};
      low_level_q <= 1'b0;
    end else begin
      line_direction_shadow_q <= line_d;
      low_level_q <= 1'b0;
    end
  end

  assign SCL_OE = line_direction_shadow_q.scl_low;
  assign SDA_OE = line_direction_shadow_q.sda_low;
  assign SCL_O = low_level_q;
  assign SDA_O = low_level_q;
  assign AVS_READDATA = rdata_q;
  assign AVS_WAITREQUEST = wait_q;

  // ==========================================================
  // assertions
  property p_idle_released;
    @(posedge CLK) disable iff (RST)
    (machine_state_q == ST_IDLE) ##1 (machine_state_q == ST_IDLE) |-> !SCL_OE && !SDA_OE;
  endproperty
  a_idle_released: assert property (p_idle_released) else $error("lines held in idle");

  property p_start_edge;
    @(posedge CLK) disable iff (RST)
    $rose(SDA_OE) && $past(machine_state_q == ST_START_COND) |-> !SCL_OE;
  endproperty
  a_start_edge: assert property (p_start_edge) else $error("start without scl high");

  property p_stop_edge;
    @(posedge CLK) disable iff (RST)
    $fell(SDA_OE) && $past(machine_state_q == ST_STOP_COND) |-> !SCL_OE && $past(!SCL_OE);
  endproperty
  a_stop_edge: assert property (p_stop_edge) else $error("stop without scl high");

  property p_never_high;
    @(posedge CLK) disable iff (RST)
    !SCL_O && !SDA_O;
  endproperty
  a_never_high: assert property (p_never_high) else $error("line driven high");

  property p_byte_preload;
    @(posedge CLK) disable iff (RST)
    (machine_state_q != ST_SHIFT_OUT) ##1 (machine_state_q == ST_SHIFT_OUT)
      |-> bits_left_counter_q == BITS_PER_BYTE;
  endproperty
  a_byte_preload: assert property (p_byte_preload) else $error("bit counter not reloaded");

  property p_nack_stop;
    @(posedge CLK) disable iff (RST)
    adv && machine_state_q == ST_SAMPLE_ACK && machine_substate_q == SUB_LAST && ack_bit_q
      |=> machine_state_q == ST_STOP_COND && no_ack_flag_q;
  endproperty
  a_nack_stop: assert property (p_nack_stop) else $error("no-ack not handled");

  property p_rx_done;
    @(posedge CLK) disable iff (RST)
    $rose(rx_complete_flag_q) |-> write_index_q == byte_count_q
      && machine_state_q == ST_STOP_COND;
  endproperty
  a_rx_done: assert property (p_rx_done) else $error("rx flag early");

  property p_one_byte;
    @(posedge CLK) disable iff (RST)
    cmd_go && cmd == CMD_WRITE_ONE |=> byte_count_q == ONE_BYTE && dir_read_q == DIR_WRITE;
  endproperty
  a_one_byte: assert property (p_one_byte) else $error("single write count wrong");

  property p_wait_idle;
    @(posedge CLK) disable iff (RST)
    AVS_READ && AVS_ADDRESS == OFS_WAIT && !AVS_WAITREQUEST |-> !busy
      && AVS_READDATA[0] == no_ack_flag_q;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("wait returned while busy");

  c_write_done: cover property (@(posedge CLK) disable iff (RST)
    machine_state_q == ST_MORE_TX ##1 machine_state_q == ST_STOP_COND);
  c_read_done: cover property (@(posedge CLK) disable iff (RST) $rose(rx_complete_flag_q));
  c_nack: cover property (@(posedge CLK) disable iff (RST) $rose(no_ack_flag_q));
  c_wait_stall: cover property (@(posedge CLK) disable iff (RST)
    AVS_READ && AVS_ADDRESS == OFS_WAIT && busy);
endmodule : i2mb_master
`default_nettype wire

// ### i2mb_slave_model.sv
// partner model: a two-wire bus slave that answers the byte engine
`timescale 1ns/1ns
`default_nettype none
module i2mb_slave_model #(
  parameter logic [6:0] DEV = 7'h50
) (
  // resolved bus lines
  input wire logic scl,
  input wire logic sda,
  // behaviour controls from the bench
  input wire logic slow,
  input wire logic [7:0] rd_base,
  // pull-low requests, never a driven high
  output logic scl_low,
  output logic sda_low,
  // captured write data
  output logic [55:0] wr_bytes,
  output logic [3:0] n_wr
);
  logic [7:0] b;
  logic stop;
  logic rd_dir;
  int k;
  // ==========================================================
  // receive one byte msb first; a rising sda while scl high is a stop
  task automatic rx(output logic [7:0] v, output logic st);
    st = 1'b0;
    for (int i = 0; i < 8 && !st; i++) begin
      @(posedge scl);
      v = {v[6:0], sda};
      @(negedge scl or posedge sda);
      st = scl;
    end
  endtask : rx
  // ack slot opens at the falling edge that ended the eighth bit; sda goes low
  // before any stretch so it never moves while scl is high
  task automatic ack_bit();
    sda_low = 1'b1;
    if (slow) begin
      scl_low = 1'b1;
      #300;
      scl_low = 1'b0;
    end
    @(negedge scl);
    sda_low = 1'b0;
  endtask : ack_bit
  // send one byte, then sample the master's ack
  task automatic tx(input logic [7:0] v, output logic nak);
    for (int i = 7; i >= 0; i--) begin
      sda_low = !v[i];
      @(negedge scl);
    end
    sda_low = 1'b0;
    @(posedge scl);
    nak = sda;
    @(negedge scl);
  endtask : tx
  // ==========================================================
  // one transaction per start condition; unknown address is left unanswered
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    n_wr = 4'h0;
    wr_bytes = '0;
    forever begin
      @(negedge sda iff scl === 1'b1);
      n_wr = 4'h0;
      rx(b, stop);
      if (b[7:1] == DEV) begin
        // direction kept apart; data bytes reuse b
        rd_dir = b[0];
        ack_bit();
        k = 0;
        stop = 1'b0;
        while (rd_dir && !stop) begin
          tx(rd_base + 8'(k), stop);
          k++;
        end
        if (!rd_dir) rx(b, stop);
        while (!rd_dir && !stop) begin
          wr_bytes = {wr_bytes[47:0], b};
          n_wr++;
          ack_bit();
          rx(b, stop);
        end
      end
    end
  end
endmodule : i2mb_slave_model
`default_nettype wire

// ### i2mb_master_test.sv
// self-checking bench for the i2c master byte engine
`timescale 1ns/1ns
`default_nettype none
module i2mb_master_test
  import i2mb_pkg::*;
;
  localparam logic [6:0] DEV = 7'h50;
  logic CLK = 1'b0, RST = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0, slow = 1'b0;
  logic [AW-1:0] AVS_ADDRESS = '0;
  logic [31:0] AVS_WRITEDATA = '0, AVS_READDATA, q;
  logic AVS_WAITREQUEST, SCL_O, SCL_OE, SDA_O, SDA_OE, s_scl, s_sda;
  logic [7:0] rd_base = 8'h00, buf_v [0:6];
  logic [55:0] wr_bytes;
  logic [3:0] n_wr;
  wire logic scl = !(SCL_OE || s_scl);
  wire logic sda = !(SDA_OE || s_sda);
  int miscompares = 0, comparisons = 0, cycles = 0, n;
  // ==========================================================
  // design and partner
  i2mb_master uut (.CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .SCL_I(scl), .SCL_O(SCL_O), .SCL_OE(SCL_OE),
    .SDA_I(sda), .SDA_O(SDA_O), .SDA_OE(SDA_OE));
  i2mb_slave_model #(.DEV(DEV)) peer (.scl(scl), .sda(sda), .slow(slow), .rd_base(rd_base),
    .scl_low(s_scl), .sda_low(s_sda), .wr_bytes(wr_bytes), .n_wr(n_wr));
  // clock and hang guard sized well above the planned traffic
  always #4 CLK = ~CLK;
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      finish_test();
    end
  end
  // ==========================================================
  // helpers
  function automatic logic [7:0] exp_rd(input int i);
    return rd_base + 8'(i);
  endfunction : exp_rd
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // avalon access held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    AVS_WRITEDATA <= d;
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask : bus
  // load address and count, issue, then block on the wait register
  task automatic run(input logic [2:0] cmd, input logic [6:0] a, input int cnt);
    bus(1'b1, OFS_ADDR, 32'(a));
    bus(1'b1, OFS_COUNT, 32'(cnt));
    bus(1'b1, OFS_CMD_STATUS, 32'(cmd));
    bus(1'b0, OFS_WAIT, '0);
  endtask : run
  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(51445));
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    chk("idle lines", 32'h0, {28'h0, SCL_OE, SDA_OE, SCL_O, SDA_O});
    bus(1'b0, OFS_TICK, '0);
    chk("tick reset", 32'(TICK_RELOAD_RST), q);
    bus(1'b0, OFS_COUNT, '0);
    chk("count reset", 32'h1, q);
    bus(1'b0, 6'h14, '0);
    chk("unmapped", 32'h0, q);
    bus(1'b1, OFS_TICK, 32'h7);
    for (int t = 0; t < 3; t++) begin
      n = (t == 0) ? 1 : (t == 1) ? 7 : 1 + $urandom_range(5);
      for (int i = 0; i < 7; i++) begin
        buf_v[i] = 8'($urandom);
        bus(1'b1, OFS_BUF0 + 6'(4 * i), 32'(buf_v[i]));
      end
      slow <= t[0];
      run(CMD_WRITE_MANY, DEV, n);
      chk("write ack", 32'h0, 32'(q[0]));
      chk("bytes written", 32'(n), 32'(n_wr));
      for (int i = 0; i < n; i++)
        chk("write byte", 32'(buf_v[i]), 32'(wr_bytes[8 * (n - 1 - i) +: 8]));
    end
    run(CMD_WRITE_ONE, DEV, 5);
    chk("one byte count", 32'h1, 32'(n_wr));
    chk("one byte data", 32'(buf_v[0]), 32'(wr_bytes[7:0]));
    bus(1'b0, OFS_COUNT, '0);
    chk("one byte forced count", 32'(ONE_BYTE), q);
    for (int t = 0; t < 2; t++) begin
      rd_base <= 8'($urandom);
      n = t ? 7 : 2 + $urandom_range(4);
      run(CMD_READ_MANY, DEV, n);
      bus(1'b0, OFS_CMD_STATUS, '0);
      chk("rx done", 32'h4, q);
      for (int i = 0; i < n; i++) begin
        bus(1'b0, OFS_BUF0 + 6'(4 * i), '0);
        chk("read byte", 32'(exp_rd(i)), q);
      end
    end
    rd_base <= 8'($urandom);
    run(CMD_READ_ONE, DEV, 5);
    chk("read one", 32'(exp_rd(0)), 32'(q[15:8]));
    bus(1'b0, OFS_BUF0, '0);
    chk("read one buffer", 32'(exp_rd(0)), q);
    run(CMD_WRITE_MANY, DEV ^ 7'h01, 3);
    chk("nack wait", 32'h1, 32'(q[0]));
    bus(1'b0, OFS_CMD_STATUS, '0);
    chk("nack flag", 32'h2, q);
    bus(1'b1, OFS_CMD_STATUS, 32'(CMD_INIT));
    bus(1'b0, OFS_CMD_STATUS, '0);
    chk("init flags", 32'h0, q);
    finish_test();
  end
endmodule : i2mb_master_test
`default_nettype wire
